// File: tdip_pkg.sv
`default_nettype none
package tdip_pkg;
  // Instruction register
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_DEV_ID = 4'h2;
  localparam logic [IR_W-1:0] IR_USER_WORD = 4'h3;
  localparam logic [IR_W-1:0] IR_ACCESS = 4'h8;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  // Data register lengths
  localparam int DR_W = 43;
  localparam int LEN_W = 6;
  localparam logic [LEN_W-1:0] LEN_BYPASS = 6'h01;
  localparam logic [LEN_W-1:0] LEN_WORD = 6'h20;
  localparam logic [LEN_W-1:0] LEN_ACC = 6'h2b;
  localparam int WORD_W = 32;
  // Identification word fields
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_W = 11;
  localparam logic ID_FIXED_ONE = 1'b1;
  // User code word fields
  localparam int UC_UNUSED_W = 6;
  localparam int UC_REV_W = 16;
  // Security register bits
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_DEBUG_OFF = 14;
  localparam int SEC_UID_MSB = 31;
  localparam int SEC_UID_LSB = 22;
  // Access targets
  localparam logic [1:0] TGT_TILE = 2'h0;
  localparam logic [1:0] TGT_SWITCH = 2'h1;
  localparam logic [1:0] TGT_OTP = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int BOOT_MAX_NS = 150000;
  localparam int BOOT_CYC = BOOT_MAX_NS / CLK_PERIOD_NS;
  localparam int BOOT_CNT_W = 12;
  localparam int RST_MIN_NS = 100;
  localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] target;
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
  } tdip_acc_t;

  typedef enum logic [3:0] {
    TS_TLR, TS_RTI, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR,
    TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UPD_IR
  } tdip_tap_state_t;
endpackage
`default_nettype wire

// File: tdip_top.sv
`timescale 1ns/100ps
`default_nettype none
module tdip_top
  import tdip_pkg::*;
#(
  parameter int BSR_W = 16,
  // Identity values are arbitrary
  parameter logic [ID_VER_W-1:0] ID_VERSION = 4'h1,
  parameter logic [ID_PART_W-1:0] ID_PART = 16'h5a5a,
  parameter logic [ID_MFR_W-1:0] ID_MFR = 11'h2aa,
  parameter logic [UC_REV_W-1:0] SIL_REV = 16'h0001
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic pll_lock_i,
  input wire logic [1:0] boot_mode_i,
  input wire logic [WORD_W-1:0] sec_reg_i,
  input wire logic sec_load_i,
  input wire logic dbg_en_i,
  input wire logic dbg_out_mode_i,
  input wire logic breakpoint_i,
  input wire logic bp_clear_i,
  input wire logic debug_pin_i,
  input wire logic [WORD_W-1:0] acc_rdata_i,
  input wire logic acc_rvalid_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [BSR_W-1:0] io_pins_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [BSR_W-1:0] bsr_out_o,
  output logic extest_o,
  output logic boot_start_o,
  output logic [1:0] boot_mode_o,
  output logic debug_o,
  output logic debug_oe_o,
  output logic debug_req_o,
  output logic acc_req_o,
  output tdip_acc_t acc_o
);

  function automatic tdip_tap_state_t tap_next(input tdip_tap_state_t s, input logic tms);
    tdip_tap_state_t n;
    n = s;
    unique case (s)
      TS_TLR: n = tms ? TS_TLR : TS_RTI;
      TS_RTI: n = tms ? TS_SEL_DR : TS_RTI;
      TS_SEL_DR: n = tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: n = tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: n = tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: n = tms ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR: n = tms ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: n = tms ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: n = tms ? TS_SEL_DR : TS_RTI;
      TS_SEL_IR: n = tms ? TS_TLR : TS_CAP_IR;
      TS_CAP_IR: n = tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: n = tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: n = tms ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR: n = tms ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: n = tms ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: n = tms ? TS_SEL_DR : TS_RTI;
    endcase
    return n;
  endfunction

  // Serial input enters at position len-1, output leaves at bit 0
  function automatic logic [DR_W-1:0] shift_dr(input logic [DR_W-1:0] sh, input logic din,
                                               input logic [LEN_W-1:0] len);
    logic [DR_W-1:0] r;
    r = '0;
    for (int i = 0; i < DR_W; i++) begin
      if (i == int'(len) - 1) begin
        r[i] = din;
      end else if (i < DR_W - 1) begin
        r[i] = sh[i+1];
      end
    end
    return r;
  endfunction

  function automatic logic [LEN_W-1:0] dr_len(input logic [IR_W-1:0] ir);
    logic [LEN_W-1:0] l;
    l = LEN_BYPASS;
    if (ir == IR_DEV_ID || ir == IR_USER_WORD) begin
      l = LEN_WORD;
    end else if (ir == IR_SAMPLE || ir == IR_EXTEST) begin
      l = LEN_W'(BSR_W);
    end else if (ir == IR_ACCESS) begin
      l = LEN_ACC;
    end
    return l;
  endfunction

  // ---------------- Core clock domain ----------------
  logic rst_ff1, rst_ff2;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_ff1 <= 1'b0;
      rst_ff2 <= 1'b0;
    end else begin
      rst_ff1 <= 1'b1;
      rst_ff2 <= rst_ff1;
    end
  end
  wire logic rst_n = rst_ff2;

  logic acc_tgl;
  logic lock_s1, lock_s2, dbg_s1, dbg_s2, acc_s1, acc_s2, acc_s3;
  logic [1:0] mode_s1, mode_s2;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      dbg_s1 <= 1'b1;
      dbg_s2 <= 1'b1;
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
      acc_s1 <= 1'b0;
      acc_s2 <= 1'b0;
      acc_s3 <= 1'b0;
    end else if (ce_i) begin
      lock_s1 <= pll_lock_i;
      lock_s2 <= lock_s1;
      dbg_s1 <= debug_pin_i;
      dbg_s2 <= dbg_s1;
      mode_s1 <= boot_mode_i;
      mode_s2 <= mode_s1;
      acc_s1 <= acc_tgl;
      acc_s2 <= acc_s1;
      acc_s3 <= acc_s2;
    end
  end

  logic [BOOT_CNT_W-1:0] boot_cnt;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt <= '0;
      boot_start_o <= 1'b0;
      boot_mode_o <= 2'h0;
    end else if (ce_i && !boot_start_o) begin
      boot_cnt <= boot_cnt + 1'b1;
      if (lock_s2 || boot_cnt == BOOT_CNT_W'(BOOT_CYC - 1)) begin
        boot_start_o <= 1'b1;
        boot_mode_o <= mode_s2;
      end
    end
  end

  logic [WORD_W-1:0] sec_hold, rd_hold;
  logic sec_tgl, rd_tgl;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sec_hold <= '0;
      sec_tgl <= 1'b0;
      rd_hold <= '0;
      rd_tgl <= 1'b0;
    end else if (ce_i) begin
      if (sec_load_i) begin
        sec_hold <= sec_reg_i;
        sec_tgl <= ~sec_tgl;
      end
      if (acc_rvalid_i) begin
        rd_hold <= acc_rdata_i;
        rd_tgl <= ~rd_tgl;
      end
    end
  end

  logic bp_hit;
  wire logic dbg_locked = sec_hold[SEC_DEBUG_OFF];
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bp_hit <= 1'b0;
      debug_o <= 1'b0;
      debug_oe_o <= 1'b0;
      debug_req_o <= 1'b0;
    end else if (ce_i) begin
      // Set wins over clear
      bp_hit <= breakpoint_i | (bp_hit & ~bp_clear_i);
      debug_o <= 1'b0;
      debug_oe_o <= dbg_en_i & dbg_out_mode_i & ~dbg_locked & (bp_hit | breakpoint_i);
      debug_req_o <= dbg_en_i & ~dbg_out_mode_i & ~dbg_locked & ~dbg_s2;
    end
  end

  tdip_acc_t acc_hold;
  wire logic acc_blocked = sec_hold[SEC_JTAG_OFF] |
                           (sec_hold[SEC_JTAG_OTP_OFF] && acc_hold.target == TGT_OTP);
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_req_o <= 1'b0;
      acc_o <= '0;
    end else if (ce_i) begin
      acc_req_o <= (acc_s2 ^ acc_s3) & ~acc_blocked;
      if ((acc_s2 ^ acc_s3) && !acc_blocked) begin
        acc_o <= acc_hold;
      end
    end
  end

  // ---------------- Test clock domain ----------------
  wire logic tap_arst_n = trst_n_i & rst_n_i;
  logic trst_ff1, tap_rst_n;
  // held in reset by TAP reset (trst_n_i) or chip reset (rst_n_i)
  always_ff @(posedge tck_i or negedge tap_arst_n) begin
    if (!tap_arst_n) begin
      trst_ff1 <= 1'b0;
      tap_rst_n <= 1'b0;
    end else begin
      trst_ff1 <= 1'b1;
      tap_rst_n <= trst_ff1;
    end
  end

  tdip_tap_state_t tap_state;
  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tap_state <= TS_TLR;
    end else begin
      tap_state <= tap_next(tap_state, tms_i);
    end
  end

  logic [BSR_W-1:0] pins_s1, pins_s2;
  logic sec_s1, sec_s2, sec_s3, rd_s1, rd_s2, rd_s3;
  logic [WORD_W-1:0] sec_t, rd_t;
  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
      {sec_s1, sec_s2, sec_s3} <= 3'h0;
      {rd_s1, rd_s2, rd_s3} <= 3'h0;
      sec_t <= '0;
      rd_t <= '0;
    end else begin
      pins_s1 <= io_pins_i;
      pins_s2 <= pins_s1;
      {sec_s1, sec_s2, sec_s3} <= {sec_tgl, sec_s1, sec_s2};
      {rd_s1, rd_s2, rd_s3} <= {rd_tgl, rd_s1, rd_s2};
      if (sec_s2 ^ sec_s3) begin
        sec_t <= sec_hold;
      end
      if (rd_s2 ^ rd_s3) begin
        rd_t <= rd_hold;
      end
    end
  end

  logic [IR_W-1:0] bs_ir, chip_ir, bs_ir_sh, chip_ir_sh;
  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bs_ir <= IR_DEV_ID;
      chip_ir <= IR_DEV_ID;
      bs_ir_sh <= '0;
      chip_ir_sh <= '0;
    end else if (tap_state == TS_TLR) begin
      bs_ir <= IR_DEV_ID;
      chip_ir <= IR_DEV_ID;
    end else if (tap_state == TS_CAP_IR) begin
      bs_ir_sh <= IR_CAPTURE;
      chip_ir_sh <= IR_CAPTURE;
    end else if (tap_state == TS_SH_IR) begin
      bs_ir_sh <= {tdi_i, bs_ir_sh[IR_W-1:1]};
      chip_ir_sh <= {bs_ir_sh[0], chip_ir_sh[IR_W-1:1]};
    end else if (tap_state == TS_UPD_IR) begin
      bs_ir <= bs_ir_sh;
      chip_ir <= (chip_ir_sh == IR_ACCESS && sec_t[SEC_JTAG_OFF]) ? IR_BYPASS : chip_ir_sh;
    end
  end

  wire logic [WORD_W-1:0] id_word = {ID_VERSION, ID_PART, ID_MFR, ID_FIXED_ONE};
  wire logic [WORD_W-1:0] user_word = {sec_t[SEC_UID_MSB:SEC_UID_LSB], {UC_UNUSED_W{1'b0}},
                                       SIL_REV};
  localparam int PAD_W = DR_W - WORD_W;

  function automatic logic [DR_W-1:0] cap_dr(input logic [IR_W-1:0] ir, input logic chip);
    logic [DR_W-1:0] c;
    c = '0;
    if (ir == IR_DEV_ID) begin
      c = {{PAD_W{1'b0}}, id_word};
    end else if (ir == IR_USER_WORD) begin
      c = {{PAD_W{1'b0}}, user_word};
    end else if (!chip && (ir == IR_SAMPLE || ir == IR_EXTEST)) begin
      c = {{(DR_W - BSR_W){1'b0}}, pins_s2};
    end else if (chip && ir == IR_ACCESS) begin
      c = {{PAD_W{1'b0}}, rd_t};
    end
    return c;
  endfunction

  logic [DR_W-1:0] bs_dr, chip_dr;
  always_ff @(posedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bs_dr <= '0;
      chip_dr <= '0;
      bsr_out_o <= '0;
      extest_o <= 1'b0;
      acc_hold <= '0;
      acc_tgl <= 1'b0;
    end else if (tap_state == TS_CAP_DR) begin
      bs_dr <= cap_dr(bs_ir, 1'b0);
      chip_dr <= cap_dr(chip_ir, 1'b1);
    end else if (tap_state == TS_SH_DR) begin
      bs_dr <= shift_dr(bs_dr, tdi_i, dr_len(bs_ir));
      chip_dr <= shift_dr(chip_dr, bs_dr[0], dr_len(chip_ir));
    end else if (tap_state == TS_UPD_DR) begin
      if (bs_ir == IR_SAMPLE || bs_ir == IR_EXTEST) begin
        bsr_out_o <= bs_dr[BSR_W-1:0];
      end
      extest_o <= (bs_ir == IR_EXTEST);
      if (chip_ir == IR_ACCESS) begin
        acc_hold <= tdip_acc_t'(chip_dr);
        acc_tgl <= ~acc_tgl;
      end
    end else if (tap_state == TS_TLR) begin
      extest_o <= 1'b0;
    end
  end

  // Output changes on the falling test clock edge
  always_ff @(negedge tck_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o <= (tap_state == TS_SH_IR) ? chip_ir_sh[0] : chip_dr[0];
      tdo_oe_o <= (tap_state == TS_SH_IR) || (tap_state == TS_SH_DR);
    end
  end

  // ---------------- Assertions ----------------
  property p_two_taps;
    @(posedge tck_i) disable iff (!tap_rst_n)
    (tap_state == TS_TLR) |=> (bs_ir == IR_DEV_ID) && (chip_ir == IR_DEV_ID);
  endproperty
  a_two_taps: assert property (p_two_taps) else $error("IR not identification after reset");

  property p_id_capture;
    @(posedge tck_i) disable iff (!tap_rst_n)
    (tap_state == TS_CAP_DR && chip_ir == IR_DEV_ID) |=>
      chip_dr[0] == 1'b1 && chip_dr[WORD_W-1:WORD_W-ID_VER_W] == ID_VERSION;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("Bad identification capture");

  property p_user_capture;
    @(posedge tck_i) disable iff (!tap_rst_n)
    (tap_state == TS_CAP_DR && chip_ir == IR_USER_WORD) |=>
      chip_dr[WORD_W-1:WORD_W-1-(SEC_UID_MSB-SEC_UID_LSB)] ==
        $past(sec_t[SEC_UID_MSB:SEC_UID_LSB]) &&
      chip_dr[UC_REV_W+UC_UNUSED_W-1:UC_REV_W] == '0;
  endproperty
  a_user_capture: assert property (p_user_capture) else $error("Bad user code capture");

  property p_trst_hold;
    @(posedge tck_i) disable iff (!rst_n_i)
    (!trst_n_i) [*2] |=> (tap_state == TS_TLR) && !tdo_oe_o;
  endproperty
  a_trst_hold: assert property (p_trst_hold) else $error("TAP left reset while held");

  property p_tms_reset;
    @(posedge tck_i) disable iff (!tap_rst_n)
    tms_i [*5] |=> (tap_state == TS_TLR);
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("Five TMS highs miss reset");

  property p_sec_lock;
    @(posedge core_clk_i) disable iff (!rst_n)
    sec_hold[SEC_JTAG_OFF] |=> !acc_req_o;
  endproperty
  a_sec_lock: assert property (p_sec_lock) else $error("Access issued while locked");

  property p_debug_bp;
    @(posedge core_clk_i) disable iff (!rst_n)
    (ce_i && breakpoint_i && dbg_en_i && dbg_out_mode_i && !dbg_locked) |=> debug_oe_o;
  endproperty
  a_debug_bp: assert property (p_debug_bp) else $error("Breakpoint did not drive pin");

  property p_debug_float;
    @(posedge core_clk_i) disable iff (!rst_n)
    (ce_i && !bp_hit && !breakpoint_i) |=> !debug_oe_o;
  endproperty
  a_debug_float: assert property (p_debug_float) else $error("Pin driven before break");

  property p_debug_in;
    @(posedge core_clk_i) disable iff (!rst_n)
    (ce_i && !dbg_s2 && dbg_en_i && !dbg_out_mode_i && !dbg_locked) |=> debug_req_o;
  endproperty
  a_debug_in: assert property (p_debug_in) else $error("Pin low missed debug entry");

  property p_debug_lock;
    @(posedge core_clk_i) disable iff (!rst_n)
    $past(dbg_locked) |-> !debug_oe_o && !debug_req_o;
  endproperty
  a_debug_lock: assert property (p_debug_lock) else $error("Debug pin used while locked");

  property p_wired_and;
    @(posedge core_clk_i) disable iff (!rst_n)
    debug_oe_o |-> !debug_o;
  endproperty
  a_wired_and: assert property (p_wired_and) else $error("Debug pin driven high");

  property p_boot_deadline;
    @(posedge core_clk_i) disable iff (!rst_n)
    !boot_start_o |-> boot_cnt < BOOT_CNT_W'(BOOT_CYC);
  endproperty
  a_boot_deadline: assert property (p_boot_deadline) else $error("Boot later than limit");

  property p_boot_lock;
    @(posedge core_clk_i) disable iff (!rst_n)
    (ce_i && lock_s2 && !boot_start_o) |=> boot_start_o && boot_mode_o == $past(mode_s2);
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("Boot not started on lock");

  c_boot: cover property (@(posedge core_clk_i) disable iff (!rst_n) $rose(boot_start_o));
  c_access: cover property (@(posedge core_clk_i) disable iff (!rst_n) acc_req_o);
  c_debug: cover property (@(posedge core_clk_i) disable iff (!rst_n) $rose(debug_oe_o));
  c_extest: cover property (@(posedge tck_i) disable iff (!tap_rst_n) $rose(extest_o));

endmodule
`default_nettype wire

// File: tdip_scan_host.sv
`timescale 1ns/100ps
`default_nettype none
module tdip_scan_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  logic oe_seen;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b0;
    oe_seen = 1'b0;
  end

  // One test clock, which stands still between frames
  task automatic step(input logic t, input logic d, output logic q);
    tms_o = t;
    tdi_o = d;
    #62.5;
    tck_o = 1'b1;
    q = tdo_i;
    if (tdo_oe_i === 1'b1) oe_seen = 1'b1;
    #62.5;
    tck_o = 1'b0;
  endtask

  task automatic set_trst(input logic v);
    trst_n_o = v;
    oe_seen = 1'b0;
  endtask

  task automatic reset_tap();
    logic q;
    trst_n_o = 1'b0;
    #200;
    repeat (3) step(1'b1, 1'b0, q);
    trst_n_o = 1'b1;
    repeat (8) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask

  // From idle to shift, n bits low first, back to idle
  task automatic shift(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~din[n-1], q);
    step(1'b0, din[n-1], q);
  endtask
endmodule
`default_nettype wire

// File: tdip_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tdip_top_tb_top;
  import tdip_pkg::*;
  // Identity values are arbitrary
  localparam logic [3:0] VER = 4'h3;
  localparam logic [15:0] PART = 16'h1c2d;
  localparam logic [10:0] MFR = 11'h155;
  localparam logic [15:0] REV = 16'h0042;
  localparam logic [31:0] IDW = {VER, PART, MFR, ID_FIXED_ONE};
  logic core_clk, rst_n, pll_lock, sec_load, dbg_en, dbg_out_mode, bp, bp_clr, ext_low, rvalid;
  logic [1:0] boot_mode;
  logic [31:0] sec_reg, rdata;
  wire logic tck, tms, tdi, trst_n, tdo, tdo_oe, boot_start, dbg_o, dbg_oe, dbg_req, acc_req;
  wire logic [1:0] boot_mode_q;
  wire logic [15:0] bsr_out;
  wire logic extest;
  logic [15:0] pins;
  wire tdip_acc_t acc;
  // Wired-AND line with pull-up
  wire logic dbg_pin = (dbg_oe ? dbg_o : 1'b1) & !ext_low;
  int mismatches, comparisons, cycles, req_cnt;
  tdip_acc_t acc_last;
  logic [63:0] q;

  tdip_scan_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  tdip_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MFR(MFR), .SIL_REV(REV)) dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(1'b1), .pll_lock_i(pll_lock),
    .boot_mode_i(boot_mode), .sec_reg_i(sec_reg), .sec_load_i(sec_load), .dbg_en_i(dbg_en),
    .dbg_out_mode_i(dbg_out_mode), .breakpoint_i(bp), .bp_clear_i(bp_clr),
    .debug_pin_i(dbg_pin), .acc_rdata_i(rdata), .acc_rvalid_i(rvalid), .tck_i(tck),
    .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .io_pins_i(pins), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .bsr_out_o(bsr_out), .extest_o(extest), .boot_start_o(boot_start),
    .boot_mode_o(boot_mode_q), .debug_o(dbg_o), .debug_oe_o(dbg_oe), .debug_req_o(dbg_req),
    .acc_req_o(acc_req), .acc_o(acc));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (acc_req === 1'b1) begin
      req_cnt++;
      acc_last = acc;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Cycles until boot start (s=0) or debug request (s=1)
  task automatic wait_hi(input int s, input int lim, output int n);
    n = 0;
    while ((s == 0 ? boot_start : dbg_req) !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic load_sec(input logic [31:0] v);
    @(posedge core_clk);
    sec_reg <= v;
    sec_load <= 1'b1;
    @(posedge core_clk);
    sec_load <= 1'b0;
    tick(2);
  endtask

  task automatic t_boot_lock();
    int n;
    chk(boot_start, 1'b0, "boot before lock");
    @(posedge core_clk);
    boot_mode <= 2'h2;
    pll_lock <= 1'b1;
    wait_hi(0, 8, n);
    chk(n >= 2 && n <= 5, 1'b1, "boot after lock");
    chk(boot_mode_q, 2'h2, "boot mode");
  endtask

  task automatic t_boot_timeout();
    int n;
    @(posedge core_clk);
    pll_lock <= 1'b0;
    #7;
    rst_n = 1'b0;
    #1;
    chk({boot_start, boot_mode_q, acc_req}, 4'h0, "async reset");
    tick(16);
    @(posedge core_clk);
    rst_n <= 1'b1;
    boot_mode <= 2'h1;
    wait_hi(0, 4000, n);
    chk(n > 3700 && n <= 3753, 1'b1, "boot without lock");
    chk(boot_mode_q, 2'h1, "boot mode");
    @(posedge core_clk);
    pll_lock <= 1'b1;
  endtask

  task automatic t_id_user();
    host.reset_tap();
    host.shift(1'b1, 8, 64'hff, q);
    chk(q[7:0], 8'h11, "ir capture");
    host.reset_tap();
    host.shift(1'b0, 64, 64'h0, q);
    chk(q, {IDW, IDW}, "id chain");
    host.shift(1'b1, 8, 64'h33, q);
    host.shift(1'b0, 64, 64'h0, q);
    chk(q, {2{10'h0, 6'h0, REV}}, "user blank");
    load_sec({10'h2b5, 22'h0});
    host.shift(1'b1, 8, 64'h33, q);
    host.shift(1'b0, 64, 64'h0, q);
    chk(q, {2{10'h2b5, 6'h0, REV}}, "user word");
  endtask

  task automatic t_access();
    tdip_acc_t a;
    int c;
    @(posedge core_clk);
    rdata <= 32'hc0de1231;
    rvalid <= 1'b1;
    @(posedge core_clk);
    rvalid <= 1'b0;
    host.shift(1'b1, 8, 64'hf8, q);
    for (int t = 0; t < 3; t++) begin
      a = '{target: 2'(t), wr: 1'b1, addr: 8'h40 + 8'(t), data: 32'h5a00_0000 + 32'(t)};
      c = req_cnt;
      host.shift(1'b0, 44, {21'h0, a}, q);
      chk(q[42:0], {11'h0, 32'hc0de1231}, "access capture");
      for (int k = 0; k < 12 && req_cnt == c; k++) tick(1);
      chk(req_cnt, c + 1, "access request");
      chk(acc_last, a, "access word");
    end
  endtask

  task automatic t_secure();
    int c;
    c = req_cnt;
    load_sec(32'h1);
    host.shift(1'b1, 8, 64'hf8, q);
    host.shift(1'b0, 3, 64'h3, q);
    chk(q[2:0], 3'b100, "locked chain");
    tick(12);
    chk(req_cnt, c, "locked access");
    load_sec(32'h2000);
    host.shift(1'b1, 8, 64'hf8, q);
    host.shift(1'b0, 44, {21'h0, TGT_OTP, 41'h0}, q);
    tick(12);
    chk(req_cnt, c, "memory access refused");
  endtask

  task automatic t_debug();
    int n;
    @(posedge core_clk);
    dbg_en <= 1'b1;
    dbg_out_mode <= 1'b1;
    tick(4);
    chk(dbg_oe, 1'b0, "pin floats");
    @(posedge core_clk);
    bp <= 1'b1;
    @(posedge core_clk);
    bp <= 1'b0;
    #1;
    chk({dbg_oe, dbg_o}, 2'b10, "pin pulled low");
    tick(3);
    chk(dbg_oe, 1'b1, "pin held");
    @(posedge core_clk);
    bp_clr <= 1'b1;
    @(posedge core_clk);
    bp_clr <= 1'b0;
    tick(1);
    chk(dbg_oe, 1'b0, "pin released");
    @(posedge core_clk);
    dbg_out_mode <= 1'b0;
    ext_low <= 1'b1;
    wait_hi(1, 8, n);
    chk(n <= 4 && dbg_req === 1'b1, 1'b1, "debug entry");
    @(posedge core_clk);
    ext_low <= 1'b0;
    tick(5);
    chk(dbg_req, 1'b0, "debug follows pin");
    load_sec(32'h4000);
    @(posedge core_clk);
    dbg_out_mode <= 1'b1;
    bp <= 1'b1;
    @(posedge core_clk);
    bp <= 1'b0;
    tick(3);
    chk(dbg_oe, 1'b0, "locked pin drive");
    @(posedge core_clk);
    dbg_out_mode <= 1'b0;
    ext_low <= 1'b1;
    tick(6);
    chk(dbg_req, 1'b0, "locked pin input");
  endtask

  // Boundary chain ahead of chip bypass bit
  task automatic t_boundary();
    host.reset_tap();
    @(posedge core_clk);
    pins <= 16'h96e1;
    host.shift(1'b1, 8, 64'h0f, q);
    host.shift(1'b0, 17, {47'h0, 16'ha5c3, 1'b1}, q);
    chk(q[16:0], {16'h96e1, 1'b0}, "boundary capture");
    chk({extest, bsr_out}, {1'b1, 16'ha5c3}, "boundary update");
    repeat (5) host.step(1'b1, 1'b0, q[0]);
    chk(extest, 1'b0, "extest cleared");
  endtask

  task automatic t_trst_hold();
    host.set_trst(1'b0);
    host.shift(1'b0, 8, 64'h5a, q);
    chk(host.oe_seen, 1'b0, "tap held in reset");
  endtask

  initial begin
    rst_n = 1'b0;
    pll_lock = 1'b0;
    boot_mode = 2'h0;
    sec_reg = 32'h0;
    sec_load = 1'b0;
    dbg_en = 1'b0;
    dbg_out_mode = 1'b0;
    bp = 1'b0;
    bp_clr = 1'b0;
    ext_low = 1'b0;
    rdata = 32'h0;
    rvalid = 1'b0;
    pins = 16'h0;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    req_cnt = 0;
    tick(16);
    @(posedge core_clk);
    rst_n <= 1'b1;
    tick(3);
    t_boot_lock();
    t_boot_timeout();
    t_id_user();
    t_access();
    t_secure();
    t_debug();
    t_boundary();
    t_trst_hold();
    close_out();
  end
endmodule
`default_nettype wire
